// File: verilog/sampling_adc_parallel_port.sv
// Purpose: Conversion control and parallel result port of a 14-bit sampling converter
// Assumes: All inputs synchronous to clk; analog difference given as two signed codes
// Notes:   Results also leave through a 32-word buffer with valid/ready
//
// Overview of operation
// - A falling edge on conversion_start_n begins a new conversion, except in the first acquire cycle or with the buffer full.
// - The input difference is captured in the same cycle as that falling edge.
// - Start edges arriving while a conversion runs are ignored.
// - busy is low for the whole conversion and rises when it ends.
// - The parallel result changes exactly when busy rises.
// - Latching on busy falling or start rising yields the previous result.
// - Each result appears at once as one 14-bit parallel word.
// - The result is two's complement of the signed input difference; the code clips out-of-range differences to full scale.
// - Conversion lasts typically 330ns and never more than 400ns; the code always takes 9 cycles, 360ns.
// - Acquisition completes within 100ns after the previous conversion ends.
// - One acquisition plus conversion fits in 454ns; host spaces starts accordingly.
// - Only one control input exists; status is reported only on busy.
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"

// ---------------------------------------------------------------
// Result buffer
// ---------------------------------------------------------------
module result_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = `RESULT_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Filling side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Draining side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   // Occupancy is kept in its own counter, one bit wider than the
   // pointers, so a full buffer and an empty one never look alike.
   // The extra flops are the price of flags that need no pointer compare.
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] count_r, count_nxt;
   logic push, pop;

   // Honest flags straight from the occupancy count
   assign in_ready = (count_r != FULL);
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update, wrapping at the depth
   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (push) begin
         wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
         rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
      end
   end

   // Storage needs no reset; entries are read only once written
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end
endmodule

// ---------------------------------------------------------------
// Converter control and parallel port
// ---------------------------------------------------------------
module sampling_adc_parallel_port #(
   parameter int CONV_CYCLES = `CONV_CYCLES,
   parameter int ACQ_CYCLES = `ACQ_CYCLES,
   parameter int FIFO_DEPTH = `RESULT_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Conversion control
   input wire logic conversion_start_n,
   // Sampled analog difference, as signed codes
   input wire logic signed [`ADC_BITS-1:0] ain_pos,
   input wire logic signed [`ADC_BITS-1:0] ain_neg,
   // Status and parallel result
   output logic busy,
   output logic [`ADC_BITS-1:0] result_data,
   // Buffered result stream
   output adc_pkg::result_word_t result_stream,
   output logic result_stream_valid,
   input wire logic result_stream_ready
);
   import adc_pkg::*;

   // Four-bit counters: CONV_CYCLES and ACQ_CYCLES must stay between 1 and 16
   localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);
   localparam logic [3:0] ACQ_LAST = 4'(ACQ_CYCLES - 1);

   conv_state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic start_n_prev_r;
   logic busy_r, busy_nxt;
   logic [`ADC_BITS-1:0] data_r, data_nxt;
   result_word_t held_r, held_nxt, sample_now;
   logic signed [`ADC_BITS:0] diff_wide;
   logic start_fall, can_launch, launch, push, fifo_in_ready;

   // Start edge on the one control input; synchronous input, no synchroniser
   assign start_fall = start_n_prev_r & ~conversion_start_n;

   // Full buffer holds off a start, so a result never has to be dropped
   // The last acquire cycle already takes a new edge; this overlap is what
   // keeps one sample-plus-conversion period at eleven cycles
   assign can_launch = (state_r == ST_IDLE) ||
                       ((state_r == ST_ACQ) && (cnt_r == ACQ_LAST));
   assign launch = start_fall & can_launch & fifo_in_ready;

   // Signed difference, clipped to the 14-bit two's complement range
   assign diff_wide = {ain_pos[`ADC_BITS-1], ain_pos} - {ain_neg[`ADC_BITS-1], ain_neg};
   always_comb begin
      sample_now.saturated = (diff_wide[`ADC_BITS] != diff_wide[`ADC_BITS-1]);
      if (sample_now.saturated) begin
         sample_now.code = diff_wide[`ADC_BITS] ? `CODE_NEG_FULL : `CODE_POS_FULL;
      end else begin
         sample_now.code = diff_wide[`ADC_BITS-1:0];
      end
   end

   // Sequencer: capture at the edge, convert, then reacquire
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      data_nxt = data_r;
      held_nxt = held_r;
      push = 1'b0;
      case (state_r)
         ST_IDLE, ST_ACQ: begin
            if (launch) begin
               held_nxt = sample_now;
               busy_nxt = 1'b0;
               state_nxt = ST_CONV;
               cnt_nxt = '0;
            end else if (state_r == ST_ACQ) begin
               if (cnt_r == ACQ_LAST) begin
                  state_nxt = ST_IDLE;
               end else begin
                  cnt_nxt = cnt_r + 4'h1;
               end
            end
         end
         ST_CONV: begin
            // Start edges here fall through untouched
            if (cnt_r == CONV_LAST) begin
               busy_nxt = 1'b1;
               data_nxt = held_r.code;
               push = 1'b1;
               state_nxt = ST_ACQ;
               cnt_nxt = '0;
            end else begin
               cnt_nxt = cnt_r + 4'h1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt = '0;
            busy_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         start_n_prev_r <= 1'b1;
         busy_r <= 1'b1;
         data_r <= `RESULT_RESET;
         held_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         start_n_prev_r <= conversion_start_n;
         busy_r <= busy_nxt;
         data_r <= data_nxt;
         held_r <= held_nxt;
      end
   end

   // Busy and data share one edge, so a host latching on busy rising
   // after the valid delay always sees the new word
   assign busy = busy_r;
   assign result_data = data_r;

   // Buffer on the result path; drained by the stream consumer
   result_fifo #(
      .WIDTH($bits(result_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) result_fifo_inst (
      .clk(clk),
      .rst(rst),
      .in_data(held_r),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .out_data(result_stream),
      .out_valid(result_stream_valid),
      .out_ready(result_stream_ready)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Rest of a conversion run: eight more low cycles, then the rise
   sequence s_busy_low_run;
      (!busy)[*8] ##1 busy;
   endsequence

   // Word held after an out-of-range difference: flagged and at full scale
   sequence s_clipped;
      held_r.saturated &&
      (held_r.code == `CODE_POS_FULL || held_r.code == `CODE_NEG_FULL);
   endsequence

   // A taken edge drops busy and enters the conversion at once
   chk_start_launch: assert property (launch |=> !busy && state_r == ST_CONV)
      else $error("start edge did not begin a conversion");
   // The held sample moves on a taken edge and at no other time
   chk_sample_edge: assert property ($changed(held_r) |-> $past(launch))
      else $error("sample changed away from a start edge");
   // An edge inside a conversion leaves the held sample alone
   chk_ignore_start: assert property (state_r == ST_CONV && start_fall |=> $stable(held_r))
      else $error("start during conversion was not ignored");
   // Low time equals the conversion count, nine cycles by default
   chk_busy_low_width: assert property ($fell(busy) |=> s_busy_low_run)
      else $error("busy low time differs from nine cycles");
   // Whatever the count, never longer than the worst-case conversion
   chk_busy_max_time: assert property ($fell(busy) |-> ##[1:10] busy)
      else $error("busy low longer than ten cycles");
   // Busy mirrors the conversion state, so it reports nothing else
   chk_busy_state: assert property ((state_r == ST_CONV) == !busy)
      else $error("busy does not follow the conversion state");
   // The word on the bus and the rise of busy share one edge
   chk_data_at_rise: assert property ($rose(busy) |-> result_data == held_r.code)
      else $error("result not updated as busy rose");
   // Between rises the bus holds, so early latching sees the old word
   chk_data_stable: assert property (!$rose(busy) |-> $stable(result_data))
      else $error("result changed without busy rising");
   // Every finished conversion leaves a copy for the buffer
   chk_word_pushed: assert property ($rose(busy) |-> $past(push))
      else $error("result word not passed on at conversion end");
   // In-range differences come out unchanged in two's complement
   chk_twos_code: assert property (launch && !sample_now.saturated |=>
      $signed(held_r.code) == $past(diff_wide))
      else $error("result is not the signed difference");
   // Out-of-range differences clip instead of wrapping around
   chk_clip_code: assert property (launch && sample_now.saturated |=> s_clipped)
      else $error("out of range difference not clipped");
   // Acquisition ends one cycle after the rise, well inside its limit
   chk_acq_window: assert property ($rose(busy) |-> ##1 can_launch)
      else $error("acquisition longer than allowed");
   // Eleven cycles from one taken edge to the next chance
   chk_throughput: assert property (launch |-> ##11 can_launch)
      else $error("throughput period exceeded");
   // A full buffer turns an edge away without starting anything
   chk_full_refuse: assert property (start_fall && can_launch && !fifo_in_ready |=>
      busy && $stable(held_r))
      else $error("start taken while the buffer was full");
endmodule

`default_nettype wire

// File: verilog/adc_consts.svh
// Purpose: Constants of the sampling converter control and parallel port
// Assumes: 25 MHz system clock
// Notes:   Times in ns as printed, cycle counts derived from them
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ---------------------------------------------------------------
// Word layout and reset values
// ---------------------------------------------------------------
`define ADC_BITS 14
`define RESULT_RESET 14'h0000
`define CODE_POS_FULL 14'h1FFF
`define CODE_NEG_FULL 14'h2000
`define RESULT_FIFO_DEPTH 32

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define CONV_TIME_NS 330
`define CONV_MAX_NS 400
`define ACQ_MAX_NS 100
`define THROUGHPUT_NS 454
`define DATA_VALID_NS 20
// Typical conversion time, rounded up to whole cycles (9)
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest times round down
`define CONV_MAX_CYCLES (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define ACQ_CYCLES (`ACQ_MAX_NS / `CLK_PERIOD_NS)
`define THROUGHPUT_CYCLES (`THROUGHPUT_NS / `CLK_PERIOD_NS)

`endif

// File: verilog/adc_pkg.sv
// Purpose: Types of the sampling converter control and parallel port
// Assumes: adc_consts.svh on the include path
// Notes:   Types only; numbers live in the constants header
`default_nettype none
`include "adc_consts.svh"

package adc_pkg;

   // Conversion sequencer, Gray coded along idle -> convert -> acquire
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_ACQ = 2'b11
   } conv_state_t;

   // One result word as it travels through the buffer
   typedef struct packed {
      logic saturated;
      logic [`ADC_BITS-1:0] code;
   } result_word_t;

endpackage

`default_nettype wire

// File: verif/adc_host_model.sv
// Purpose: Host logic that starts conversions and latches result words
// Assumes: Same clock as the converter; one-cycle go request from the bench
// Notes:   Keeps both the fresh word and the word seen at the busy fall
`timescale 1ns/1ps
`default_nettype none

module adc_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bench request
   input wire logic go,
   // Converter side
   input wire logic busy,
   input wire logic [13:0] result_data,
   output logic conversion_start_n,
   // Latched words
   output logic [13:0] new_word,
   output logic [13:0] old_word,
   output logic got
);
   logic busy_q;

   // Start edge per request; rise detected on a registered copy of busy
   always_ff @(posedge clk) begin
      if (rst) begin
         conversion_start_n <= 1'b1;
         busy_q <= 1'b1;
         got <= 1'b0;
      end else begin
         conversion_start_n <= ~go;
         busy_q <= busy;
         got <= busy & ~busy_q;
         // Latch one cycle after the rise, well past the settle delay
         if (busy & ~busy_q) begin
            new_word <= result_data;
         end
         // Word taken at the fall still belongs to the previous conversion
         if (~busy & busy_q) begin
            old_word <= result_data;
         end
      end
   end
endmodule

`default_nettype wire

// File: verif/tb_sampling_adc_parallel_port.sv
// Purpose: Self-checking bench of the converter control and parallel port
// Assumes: 25 MHz clock, nine-cycle conversion, 32-word result buffer
// Notes:   Host model drives the start input; bench drives the analog codes
`timescale 1ns/1ps
`default_nettype none

`define CHECK_EQ(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin bad_count++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end

module tb_sampling_adc_parallel_port;
   import adc_pkg::*;
   localparam int CONV = 9;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic ready = 1'b1;
   logic signed [13:0] ain_pos = 14'h0000;
   logic signed [13:0] ain_neg = 14'h0000;
   logic conversion_start_n, busy, sv, got;
   logic [13:0] result_data, new_word, old_word;
   result_word_t sw;
   int bad_count = 0;
   int checks_done = 0;

   always #20 clk = ~clk;

   sampling_adc_parallel_port #(.CONV_CYCLES(CONV), .ACQ_CYCLES(2), .FIFO_DEPTH(32))
   sampling_adc_parallel_port_inst (.clk(clk), .rst(rst),
      .conversion_start_n(conversion_start_n), .ain_pos(ain_pos), .ain_neg(ain_neg),
      .busy(busy), .result_data(result_data), .result_stream(sw),
      .result_stream_valid(sv), .result_stream_ready(ready));

   adc_host_model adc_host_model_inst (.clk(clk), .rst(rst), .go(go), .busy(busy),
      .result_data(result_data), .conversion_start_n(conversion_start_n),
      .new_word(new_word), .old_word(old_word), .got(got));

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // One conversion; extra fires a second start in mid-conversion
   task automatic conv(input logic signed [13:0] p, input logic signed [13:0] n,
                       input logic s, input logic [13:0] e, input logic extra);
      int k;
      logic [13:0] prev;
      prev = result_data;
      ain_pos <= p;
      ain_neg <= n;
      go <= 1'b1;
      tick();
      go <= 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 20) begin tick(); k++; end
      `CHECK_EQ("data_held", prev, result_data)
      k = 0;
      while (busy === 1'b0 && k < 20) begin
         go <= (extra && k == 3);
         tick();
         k++;
      end
      `CHECK_EQ("busy_low", CONV, k)
      `CHECK_EQ("data_at_rise", e, result_data)
      if (ready === 1'b1) `CHECK_EQ("stream", {s, e}, sw)
      `CHECK_EQ("stream_valid", 1'b1, sv)
      tick();
      `CHECK_EQ("host_word", e, new_word)
      `CHECK_EQ("host_got", 1'b1, got)
      `CHECK_EQ("fall_word", prev, old_word)
      repeat (3) begin tick(); `CHECK_EQ("no_restart", 1'b1, busy); end
   endtask

   // Codes across the range, clipping at both ends
   task automatic t_codes();
      conv(14'h0064, 14'h3FCE, 1'b0, 14'h0096, 1'b0);
      conv(14'h3FFD, 14'h0005, 1'b0, 14'h3FF8, 1'b0);
      conv(14'h1FFF, 14'h3FFF, 1'b1, 14'h1FFF, 1'b0);
      conv(14'h2000, 14'h0001, 1'b1, 14'h2000, 1'b0);
      conv(14'h0000, 14'h0000, 1'b0, 14'h0000, 1'b1);
   endtask

   // Fill the buffer until starts are refused, then drain it while it empties
   task automatic t_fill();
      int k;
      ready <= 1'b0;
      for (int i = 0; i < 32; i++) conv(14'(i), 14'h0000, 1'b0, 14'(i), 1'b0);
      go <= 1'b1;
      tick();
      go <= 1'b0;
      repeat (15) begin tick(); `CHECK_EQ("full_refuse", 1'b1, busy); end
      `CHECK_EQ("head", 15'h0000, sw)
      ready <= 1'b1;
      k = 0;
      while (sv === 1'b1 && k < 40) begin
         `CHECK_EQ("drain_word", {1'b0, 14'(k)}, sw)
         tick();
         k++;
      end
      `CHECK_EQ("drained", 32, k)
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      tick();
      `CHECK_EQ("reset_busy", 1'b1, busy)
      `CHECK_EQ("reset_data", 14'h0000, result_data)
      `CHECK_EQ("reset_valid", 1'b0, sv)
      t_codes();
      t_fill();
      end_of_test();
   end

   // Watchdog well past the roughly 620 cycles the tests take
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
endmodule

`default_nettype wire
